// File: sasb_pkg.sv
// Function
// - Divider realign sets sticky bit three
// - Bit two shows last SYSREF phase match
// - Divider alignment bit ignores host writes
// - Oscillator sync event sets sticky bit one
// - SYSREF detect sets bit zero, W1C rearms
// - Link fall while enabled sets alarm seven
// - Link down past timer limit sets six
// - Enabled lane CRC in 64b/66b sets five
// - Any chip reset sets alarm bit one
// - Misaligned SYSREF edge sets alarm bit zero
// - Mask seven keeps link loss off output
// - Masks six, five, zero gate their alarms
// - Mute mask resets to 21h
// - CRC alarm (live fault in recovery) mutes unless CRC block set
// - Misalign alarm mutes unless block set
package sasb_pkg;

  // ==========================================================
  // Widths
  localparam int LANES   = 16;
  localparam int TIMER_W = 16;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] SYNC_STATUS_ADDR  = 12'h410;
  localparam logic [11:0] ALARM_STATUS_ADDR = 12'h430;
  localparam logic [11:0] ALARM_MASK_ADDR   = 12'h431;
  localparam logic [11:0] MUTE_MASK_ADDR    = 12'h432;

  // ==========================================================
  // Field positions
  localparam int SYNC_REALIGN_BIT   = 3;
  localparam int SYNC_ALIGN_OK_BIT  = 2;
  localparam int SYNC_OSC_BIT       = 1;
  localparam int SYNC_SYSREF_BIT    = 0;
  localparam int ALM_LOSS_BIT       = 7;
  localparam int ALM_TIMEOUT_BIT    = 6;
  localparam int ALM_CRC_BIT        = 5;
  localparam int ALM_RESET_BIT      = 1;
  localparam int ALM_MISALIGN_BIT   = 0;
  localparam int MUTE_CRC_BIT       = 5;
  localparam int MUTE_MISALIGN_BIT  = 0;

  // ==========================================================
  // Bit groups and reset values
  localparam logic [7:0] SYNC_W1C_BITS    = 8'h0B;
  localparam logic [7:0] ALM_W1C_BITS     = 8'hE3;
  localparam logic [7:0] ALM_MASKABLE     = 8'hE1;
  localparam logic [7:0] SYNC_RESET       = 8'h00;
  localparam logic [7:0] ALM_RESET        = 8'h02;
  localparam logic [7:0] ALARM_MASK_RESET = 8'h00;
  localparam logic [7:0] MUTE_MASK_RESET  = 8'h21;
  localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
  localparam logic [TIMER_W-1:0] TIMER_ONE  = 16'h0001;

  // ==========================================================
  // Link-down timer states
  typedef enum logic [2:0] {
    SASB_TMR_IDLE    = 3'h1,
    SASB_TMR_COUNT   = 3'h2,
    SASB_TMR_EXPIRED = 3'h4
  } sasb_tmr_state_t;

endpackage : sasb_pkg

// File: sasb_link_timer.sv
`timescale 1ns/1ps
module sasb_link_timer
  import sasb_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  input  wire logic               i_enable,
  input  wire logic               i_link_up,
  input  wire logic [TIMER_W-1:0] i_limit,
  output logic                    o_expired
);

  // ==========================================================
  // Down-time counter
  sasb_tmr_state_t    state_q, state_d;
  logic [TIMER_W-1:0] cnt_q, cnt_d;
  logic               exp_q, exp_d;
  logic               down;

  assign down = i_enable & ~i_link_up;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    exp_d   = 1'b0;
    case (state_q)
      SASB_TMR_IDLE: begin
        cnt_d = TIMER_ZERO;
        if (down) begin
          state_d = SASB_TMR_COUNT;
        end
      end
      SASB_TMR_COUNT: begin
        if (!down) begin
          state_d = SASB_TMR_IDLE;
        end else if (cnt_q == i_limit) begin
          // One pulse per down episode, not a level
          state_d = SASB_TMR_EXPIRED;
          exp_d   = 1'b1;
        end else begin
          cnt_d = cnt_q + TIMER_ONE;
        end
      end
      SASB_TMR_EXPIRED: begin
        if (!down) begin
          state_d = SASB_TMR_IDLE;
        end
      end
      default: begin
        state_d = SASB_TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= SASB_TMR_IDLE;
      cnt_q   <= TIMER_ZERO;
      exp_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      exp_q   <= exp_d;
    end
  end

  assign o_expired = exp_q;

endmodule : sasb_link_timer

// File: sasb_status_bank.sv
`timescale 1ns/1ps
module sasb_status_bank
  import sasb_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  input  wire logic [11:0]        i_reg_addr,
  input  wire logic               i_reg_wr,
  input  wire logic [7:0]         i_reg_wdata,
  input  wire logic               i_reg_rd,
  output logic      [7:0]         o_reg_rdata,
  input  wire logic               i_sysref_detect,
  input  wire logic               i_sysref_phase_match,
  input  wire logic               i_div_realign,
  input  wire logic               i_osc_sync_event,
  input  wire logic               i_serial_link_enable,
  input  wire logic               i_link_up,
  input  wire logic [TIMER_W-1:0] i_link_down_timer_limit,
  input  wire logic               i_enc_64b66b,
  input  wire logic [LANES-1:0]   i_lane_enable,
  input  wire logic [LANES-1:0]   i_lane_crc_fault,
  input  wire logic               i_div_misalign_event,
  input  wire logic               i_link_misalign_event,
  input  wire logic               i_crc_mute_recovery,
  output logic                    o_alarm,
  output logic                    o_mute
);

  // ==========================================================
  // Decode
  logic       wr_sync, wr_alm, wr_mask, wr_mute;
  logic [7:0] sync_q, sync_d, sync_set;
  logic [7:0] alm_q, alm_d, alm_set;
  logic [7:0] mask_q, mask_d;
  logic [7:0] mute_q, mute_d;
  logic [7:0] rdata_q, rdata_d;
  logic       link_up_q;
  logic       alarm_q, alarm_d;
  logic       mute_out_q, mute_out_d;
  logic       tmr_expired;
  logic       crc_fault_any;

  assign wr_sync = i_reg_wr & (i_reg_addr == SYNC_STATUS_ADDR);
  assign wr_alm  = i_reg_wr & (i_reg_addr == ALARM_STATUS_ADDR);
  assign wr_mask = i_reg_wr & (i_reg_addr == ALARM_MASK_ADDR);
  assign wr_mute = i_reg_wr & (i_reg_addr == MUTE_MASK_ADDR);

  // ==========================================================
  // Event sources
  sasb_link_timer u_link_timer (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_enable  (i_serial_link_enable),
    .i_link_up (i_link_up),
    .i_limit   (i_link_down_timer_limit),
    .o_expired (tmr_expired)
  );

  assign crc_fault_any = |(i_lane_crc_fault & i_lane_enable);

  always_comb begin
    sync_set                   = 8'h00;
    sync_set[SYNC_REALIGN_BIT] = i_div_realign;
    sync_set[SYNC_OSC_BIT]     = i_osc_sync_event;
    sync_set[SYNC_SYSREF_BIT]  = i_sysref_detect;
    alm_set                    = 8'h00;
    alm_set[ALM_LOSS_BIT]      = link_up_q & ~i_link_up & i_serial_link_enable;
    alm_set[ALM_TIMEOUT_BIT]   = tmr_expired;
    alm_set[ALM_CRC_BIT]       = i_enc_64b66b & crc_fault_any;
    alm_set[ALM_MISALIGN_BIT]  = i_div_misalign_event |
                                 (i_link_misalign_event & i_serial_link_enable);
  end

  // ==========================================================
  // Sticky bits: set dominates a same-cycle clear
  for (genvar b = 0; b < 8; b++) begin : g_sticky
    always_comb begin
      alm_d[b] = 1'b0;
      if (ALM_W1C_BITS[b]) begin
        alm_d[b] = alm_set[b] | (alm_q[b] & ~(wr_alm & i_reg_wdata[b]));
      end
    end
    // Alignment bit has its own driver below
    if (b != SYNC_ALIGN_OK_BIT) begin : g_sync
      always_comb begin
        sync_d[b] = 1'b0;
        if (SYNC_W1C_BITS[b]) begin
          sync_d[b] = sync_set[b] | (sync_q[b] & ~(wr_sync & i_reg_wdata[b]));
        end
      end
    end
  end

  // ==========================================================
  // Alignment, masks, readback, outputs
  always_comb begin
    sync_d[SYNC_ALIGN_OK_BIT] = sync_q[SYNC_ALIGN_OK_BIT];
    // Only a SYSREF updates it; host writes never reach it
    if (i_sysref_detect) begin
      sync_d[SYNC_ALIGN_OK_BIT] = i_sysref_phase_match;
    end
    mask_d  = wr_mask ? i_reg_wdata : mask_q;
    mute_d  = wr_mute ? i_reg_wdata : mute_q;
    rdata_d = rdata_q;
    if (i_reg_rd) begin
      case (i_reg_addr)
        SYNC_STATUS_ADDR:  rdata_d = sync_q;
        ALARM_STATUS_ADDR: rdata_d = alm_q & ALM_W1C_BITS;
        ALARM_MASK_ADDR:   rdata_d = mask_q;
        MUTE_MASK_ADDR:    rdata_d = mute_q;
        default:           rdata_d = RDATA_UNMAPPED;
      endcase
    end
    // Reset alarm has no mask bit, so it always reaches the output
    alarm_d = |(alm_q & ALM_W1C_BITS & ~(mask_q & ALM_MASKABLE));
    // Recovery set: mute follows live fault, else the sticky alarm
    mute_out_d = (~mute_q[MUTE_CRC_BIT] &
                  (i_crc_mute_recovery ? crc_fault_any : alm_q[ALM_CRC_BIT])) |
                 (~mute_q[MUTE_MISALIGN_BIT] & alm_q[ALM_MISALIGN_BIT]);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync_q     <= SYNC_RESET;
      alm_q      <= ALM_RESET;
      mask_q     <= ALARM_MASK_RESET;
      mute_q     <= MUTE_MASK_RESET;
      rdata_q    <= RDATA_UNMAPPED;
      link_up_q  <= 1'b0;
      alarm_q    <= 1'b0;
      mute_out_q <= 1'b0;
    end else begin
      sync_q     <= sync_d;
      alm_q      <= alm_d;
      mask_q     <= mask_d;
      mute_q     <= mute_d;
      rdata_q    <= rdata_d;
      link_up_q  <= i_link_up;
      alarm_q    <= alarm_d;
      mute_out_q <= mute_out_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_alarm     = alarm_q;
  assign o_mute      = mute_out_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_link_fall;
    i_serial_link_enable && link_up_q && !i_link_up;
  endsequence

  sequence s_sysref_clear;
    wr_sync && i_reg_wdata[SYNC_SYSREF_BIT] && !i_sysref_detect;
  endsequence

  a_sysref_rearm: assert property (s_sysref_clear |=> !sync_q[SYNC_SYSREF_BIT])
    else $error("SYSREF flag not cleared by write of one");
  a_set_wins: assert property (i_sysref_detect && wr_sync |=> sync_q[SYNC_SYSREF_BIT])
    else $error("SYSREF event lost to same-cycle clear");
  a_align_readonly: assert property (wr_sync && !i_sysref_detect |=> $stable(sync_q[SYNC_ALIGN_OK_BIT]))
    else $error("Alignment bit changed by host write");
  a_link_loss: assert property (s_link_fall |=> alm_q[ALM_LOSS_BIT] ##1 o_alarm || mask_q[ALM_LOSS_BIT])
    else $error("Link fall did not raise link-loss alarm");
  a_crc_set: assert property (i_enc_64b66b && crc_fault_any |=> alm_q[ALM_CRC_BIT])
    else $error("Lane CRC fault did not raise CRC alarm");
  a_zero_write: assert property (wr_alm && !i_reg_wdata[ALM_LOSS_BIT] && alm_q[ALM_LOSS_BIT]
    |=> alm_q[ALM_LOSS_BIT])
    else $error("Write of zero cleared an alarm");
  a_alarm_out: assert property (((alm_q & ALM_W1C_BITS & ~(mask_q & ALM_MASKABLE)) == 8'h00)
    |=> !o_alarm)
    else $error("Alarm output set with all alarms masked");
  a_mute_block: assert property (mute_q[MUTE_CRC_BIT] && mute_q[MUTE_MISALIGN_BIT] |=> !o_mute)
    else $error("Mute raised while both blocks set");
  a_mute_reset: assert property (@(posedge i_clock) $fell(i_rst) |-> mute_q == MUTE_MASK_RESET)
    else $error("Mute mask reset value wrong");
  a_timeout_set: assert property (tmr_expired |=> alm_q[ALM_TIMEOUT_BIT])
    else $error("Timer expiry did not raise timeout alarm");

endmodule : sasb_status_bank

// File: sasb_status_bank_bench.sv
`timescale 1ns/1ps
module sasb_status_bank_bench;
  import sasb_pkg::*;
  // ==========================================================
  // Signals
  logic               clk, rst, wr, rd, sd, pm, ra, os, en, up, enc, dm, lm, rec;
  logic               alarm, mute;
  logic [11:0]        addr;
  logic [7:0]         wd, rdata;
  logic [TIMER_W-1:0] lim;
  logic [LANES-1:0]   le, lc;
  int                 mismatches = 0;
  int                 tests_run  = 0;
  int                 cycles     = 0;

  sasb_status_bank sasb_status_bank_inst (
    .i_clock(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_sysref_detect(sd), .i_sysref_phase_match(pm), .i_div_realign(ra),
    .i_osc_sync_event(os), .i_serial_link_enable(en), .i_link_up(up),
    .i_link_down_timer_limit(lim), .i_enc_64b66b(enc), .i_lane_enable(le),
    .i_lane_crc_fault(lc), .i_div_misalign_event(dm),
    .i_link_misalign_event(lm), .i_crc_mute_recovery(rec),
    .o_alarm(alarm), .o_mute(mute));

  // ==========================================================
  // Helpers
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // Strobe released one cycle later, so calls never collide
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg

  task automatic rreg(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk8(rdata, exp);
  endtask : rreg

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse

  // ==========================================================
  // Scenarios
  task automatic t_reset_values();
    rreg(SYNC_STATUS_ADDR, 8'h00);
    rreg(ALARM_STATUS_ADDR, 8'h02);
    rreg(ALARM_MASK_ADDR, 8'h00);
    rreg(MUTE_MASK_ADDR, 8'h21);
    rreg(12'h400, 8'h00);
    chk1(alarm, 1'b1);
    chk1(mute, 1'b0);
  endtask : t_reset_values

  task automatic t_sync_flags();
    pm = 1'b1;
    pulse(sd);
    pulse(ra);
    pulse(os);
    rreg(SYNC_STATUS_ADDR, 8'h0F);
    wreg(SYNC_STATUS_ADDR, 8'h00);
    rreg(SYNC_STATUS_ADDR, 8'h0F);
    wreg(SYNC_STATUS_ADDR, 8'hFF);
    rreg(SYNC_STATUS_ADDR, 8'h04);
    pm = 1'b0;
    pulse(sd);
    rreg(SYNC_STATUS_ADDR, 8'h01);
    wreg(SYNC_STATUS_ADDR, 8'h01);
    rreg(SYNC_STATUS_ADDR, 8'h00);
    pulse(sd);
    rreg(SYNC_STATUS_ADDR, 8'h01);
    // Clearing write racing a new event
    @(negedge clk);
    addr = SYNC_STATUS_ADDR;
    wd = 8'h02;
    wr = 1'b1;
    os = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    os = 1'b0;
    rreg(SYNC_STATUS_ADDR, 8'h03);
  endtask : t_sync_flags

  task automatic t_link_loss();
    wreg(ALARM_STATUS_ADDR, 8'hFF);
    rreg(ALARM_STATUS_ADDR, 8'h00);
    tick(2);
    chk1(alarm, 1'b0);
    en = 1'b1;
    tick(2);
    up = 1'b0;
    tick(1);
    up = 1'b1;
    rreg(ALARM_STATUS_ADDR, 8'h80);
    chk1(alarm, 1'b1);
    wreg(ALARM_MASK_ADDR, 8'h80);
    tick(2);
    chk1(alarm, 1'b0);
    wreg(ALARM_STATUS_ADDR, 8'h80);
    en = 1'b0;
    up = 1'b0;
    tick(2);
    up = 1'b1;
    rreg(ALARM_STATUS_ADDR, 8'h00);
  endtask : t_link_loss

  // Loss alarm stays masked so the output shows the timer alone
  task automatic t_timeout();
    en = 1'b1;
    tick(2);
    up = 1'b0;
    tick(8);
    chk1(alarm, 1'b0);
    tick(6);
    chk1(alarm, 1'b1);
    up = 1'b1;
    rreg(ALARM_STATUS_ADDR, 8'hC0);
    wreg(ALARM_MASK_ADDR, 8'hC0);
    tick(2);
    chk1(alarm, 1'b0);
    wreg(ALARM_STATUS_ADDR, 8'hC0);
  endtask : t_timeout

  task automatic t_crc_mute();
    le = 16'h0008;
    lc = 16'h0004;
    tick(2);
    enc = 1'b0;
    lc = 16'h0008;
    tick(2);
    lc = 16'h0000;
    rreg(ALARM_STATUS_ADDR, 8'h00);
    enc = 1'b1;
    lc = 16'h0008;
    tick(1);
    lc = 16'h0000;
    rreg(ALARM_STATUS_ADDR, 8'h20);
    chk1(alarm, 1'b1);
    chk1(mute, 1'b0);
    wreg(MUTE_MASK_ADDR, 8'h00);
    tick(2);
    chk1(mute, 1'b1);
    // Recovery set: mute tracks the live fault, not the sticky bit
    rec = 1'b1;
    lc = 16'h0008;
    tick(2);
    chk1(mute, 1'b1);
    lc = 16'h0000;
    tick(2);
    chk1(mute, 1'b0);
    rec = 1'b0;
    tick(2);
    chk1(mute, 1'b1);
    wreg(ALARM_STATUS_ADDR, 8'h20);
    tick(2);
    chk1(mute, 1'b0);
  endtask : t_crc_mute

  task automatic t_misalign();
    en = 1'b0;
    pulse(lm);
    rreg(ALARM_STATUS_ADDR, 8'h00);
    pulse(dm);
    rreg(ALARM_STATUS_ADDR, 8'h01);
    chk1(mute, 1'b1);
    wreg(MUTE_MASK_ADDR, 8'h01);
    tick(2);
    chk1(mute, 1'b0);
    wreg(ALARM_MASK_ADDR, 8'h01);
    tick(2);
    chk1(alarm, 1'b0);
    wreg(ALARM_STATUS_ADDR, 8'h01);
    en = 1'b1;
    pulse(lm);
    rreg(ALARM_STATUS_ADDR, 8'h01);
  endtask : t_misalign

  task automatic t_rereset();
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    rreg(ALARM_STATUS_ADDR, 8'h02);
    rreg(MUTE_MASK_ADDR, 8'h21);
    rreg(ALARM_MASK_ADDR, 8'h00);
  endtask : t_rereset

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Whole run needs about 160 cycles; hang ceiling well above
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    {rst, wr, rd, sd, pm, ra, os} = 7'h40;
    {en, up, enc, dm, lm, rec} = 6'h10;
    addr = 12'h000;
    wd = 8'h00;
    lim = 16'h0008;
    le = 16'h0000;
    lc = 16'h0000;
    tick(16);
    rst = 1'b0;
    t_reset_values();
    t_sync_flags();
    t_link_loss();
    t_timeout();
    t_crc_mute();
    t_misalign();
    t_rereset();
    end_of_test();
  end
endmodule : sasb_status_bank_bench
